// ===== rtc_capture.sv
// rtc_capture: real-time trace capture with event logic, write filter and circular trace memory
// assumes: traced bus cycle fields arrive from pins and pass two flops here; APB on pclk
//
// Functional notes
// [RL1] break range keeps last cycles before halt
// [RL2] before range keeps cycles preceding trace hit
// [RL3] about range keeps half before, half after
// [RL4] after range records full depth after hit
// [RL5] full range records first cycles, ignores events
// [RL6] total mode stores every bus cycle
// [RL7] pick-up mode stores cycles with condition true
// [RL8] exclude mode stores cycles with condition false
// [RL9] cycle gating true only at start event
// [RL10] level gating holds while start event present; here it uses the pass-counted hit_now, same as cycle gating
// [RL11] interval gating runs from start to end
// [RL12] events built from break detector kinds
// [RL13] pass count 1..255, one under same-time AND
// [RL14] events combine as AND, same-time, OR, sequencer
// [RL15] circular buffer with post-trigger countdown freeze
// [RL16] entry holds address, data, status, triggers, timestamp
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module rtc_capture
  import rtc_pkg::*;
#(
  parameter int DEPTH_LOG2 = 18
)(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  cyc_strobe_n,
  input  wire logic [RTC_ADDR_W-1:0] cyc_addr,
  input  wire logic [RTC_DATA_W-1:0] cyc_data,
  input  wire logic                  cyc_bhe_n,
  input  wire logic [3:0]            cyc_status,
  input  wire logic                  cyc_rnw,
  input  wire logic                  cyc_fetch,
  input  wire logic                  cyc_bit,
  input  wire logic                  cyc_int,
  input  wire logic [7:0]            ext_in,
  input  wire logic                  user_halt,
  output logic                       trace_active,
  output logic                       trace_done
);
  localparam int DEPTH = 1 << DEPTH_LOG2;
  localparam logic [DEPTH_LOG2:0] FULL_N = (DEPTH_LOG2+1)'(DEPTH);
  localparam logic [DEPTH_LOG2:0] HALF_N = (DEPTH_LOG2+1)'(DEPTH / 2);
  localparam int EW = RTC_ADDR_W + RTC_DATA_W + 1 + 4 + 1 + 8;

  // two-flop synchroniser on all traced pins
  localparam int SW = 1 + RTC_ADDR_W + RTC_DATA_W + 1 + 4 + 1 + 1 + 1 + 1 + 8 + 1;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {~cyc_strobe_n, cyc_addr, cyc_data, cyc_bhe_n, cyc_status, cyc_rnw,
                    cyc_fetch, cyc_bit, cyc_int, ext_in, user_halt};
      sync2_reg <= sync1_reg;
    end
  end
  logic                  s_valid, s_bhe_n, s_rnw, s_fetch, s_bit, s_int, s_halt;
  logic [RTC_ADDR_W-1:0] s_addr;
  logic [RTC_DATA_W-1:0] s_data;
  logic [3:0]            s_status;
  logic [7:0]            s_ext;
  assign {s_valid, s_addr, s_data, s_bhe_n, s_status, s_rnw, s_fetch, s_bit, s_int, s_ext, s_halt} = sync2_reg;

  // configuration registers
  logic [31:0]           ctrl_reg, ctrl_next;
  logic [31:0]           wcond_reg, wcond_next;
  logic [31:0]           comb_reg, comb_next;
  logic [31:0]           evta_reg [RTC_NEVT];
  logic [31:0]           evta_next [RTC_NEVT];
  logic [31:0]           evtk_reg [RTC_NEVT];
  logic [31:0]           evtk_next [RTC_NEVT];
  logic [DEPTH_LOG2-1:0] rdidx_reg, rdidx_next;
  logic [31:0]           prdata_reg, prdata_next;
  logic                  pready_reg, pready_next;
  logic                  pslverr_reg, pslverr_next;
  logic                  clr_pulse;

  // ctrl: [0] run, [3:1] range, [4] clear pulse
  rtc_range_t range;
  rtc_wmode_t wmode;
  rtc_gate_t  gate;
  rtc_comb_t  comb;
  assign range = rtc_range_t'(ctrl_reg[3:1]);
  assign wmode = rtc_wmode_t'(wcond_reg[1:0]);
  assign gate  = rtc_gate_t'(wcond_reg[3:2]);
  assign comb  = rtc_comb_t'(comb_reg[1:0]);

  // trace memory in flip-flops
  logic [EW-1:0]         mem_reg [DEPTH];
  logic [RTC_TS_W-1:0]   ts_mem_reg [DEPTH];
  logic [DEPTH_LOG2-1:0] wptr_reg, wptr_next;
  logic [DEPTH_LOG2:0]   fill_reg, fill_next;
  logic [DEPTH_LOG2:0]   post_reg, post_next;
  logic [RTC_TS_W-1:0]   ts_reg;
  rtc_state_t            st_reg, st_next;
  logic [1:0]            seq_reg, seq_next;
  logic                  gate_reg, gate_next;

  // event detectors
  logic [RTC_NEVT-1:0] ev_hit, ev_sat;
  genvar gi;
  generate
    for (gi = 0; gi < RTC_NEVT; gi++) begin : g_evt
      rtc_event u_evt (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (clr_pulse),
        .cyc_valid (s_valid),
        .bus_addr  (s_addr),
        .bus_rd    (s_rnw),
        .bus_wr    (~s_rnw),
        .bus_fetch (s_fetch),
        .bus_bit   (s_bit),
        .bus_int   (s_int),
        .ext_trig  (s_ext[6]),
        .match_addr(evta_reg[gi][RTC_ADDR_W-1:0]),
        .match_mask({evtk_reg[gi][31:16], 8'h00}),
        .kind      (rtc_kind_t'(evtk_reg[gi][2:0])),
        .pass_cnt  (evtk_reg[gi][15:8]),
        .pass_one  (comb == RTC_COMB_SAME),
        .hit_now   (ev_hit[gi]),
        .satisfied (ev_sat[gi])
      );
    end
  endgenerate

  // event combination; enable mask in comb_reg[7:4]
  logic [RTC_NEVT-1:0] en;
  logic                trig_fire;
  logic                start_ev, end_ev, cond;
  assign en = comb_reg[7:4];
  always_comb begin
    trig_fire = 1'b0;
    seq_next  = seq_reg;
    unique case (comb)
      RTC_COMB_AND:  trig_fire = (en != '0) && (((ev_sat | ev_hit) & en) == en);  // [RL14]
      RTC_COMB_SAME: trig_fire = (en != '0) && ((ev_hit & en) == en);             // [RL14]
      RTC_COMB_OR:   trig_fire = |(ev_hit & en);                                   // [RL14]
      RTC_COMB_SEQ: begin
        // state n advances on event n; event 3 in state 3 fires
        if (ev_hit[seq_reg]) begin
          if (seq_reg == 2'd3) begin
            trig_fire = 1'b1;                                                      // [RL14]
            seq_next  = 2'd0;
          end else begin
            seq_next = seq_reg + 2'd1;
          end
        end
      end
    endcase
    if (clr_pulse) begin
      seq_next = 2'd0;
    end
  end

  // write condition gating; start/end event select in wcond_reg[5:4]/[7:6]
  always_comb begin
    start_ev  = ev_hit[wcond_reg[5:4]];
    end_ev    = ev_hit[wcond_reg[7:6]];
    gate_next = gate_reg;
    cond      = 1'b0;
    unique case (gate)
      RTC_GATE_CYCLE: cond = start_ev;                                             // [RL9]
      RTC_GATE_LEVEL: cond = start_ev;                                             // [RL10]
      RTC_GATE_INTERVAL: begin
        cond = gate_reg | start_ev;                                                // [RL11]
        if (start_ev) begin
          gate_next = 1'b1;
        end
        if (end_ev && (gate_reg || start_ev)) begin
          gate_next = 1'b0;                                                        // [RL11]
        end
      end
      default: cond = 1'b0;
    endcase
    if (clr_pulse) begin
      gate_next = 1'b0;
    end
  end

  // level gating uses the pass-counted hit_now, the same signal as cycle gating
  logic store;
  always_comb begin
    unique case (wmode)
      RTC_WR_TOTAL:   store = s_valid;                                             // [RL6]
      RTC_WR_PICK:    store = s_valid && cond;                                     // [RL7]
      RTC_WR_EXCLUDE: store = s_valid && !cond;                                    // [RL8]
      default:        store = 1'b0;
    endcase
  end

  // capture state machine and circular write pointer
  logic do_write;
  always_comb begin
    st_next   = st_reg;
    wptr_next = wptr_reg;
    fill_next = fill_reg;
    post_next = post_reg;
    do_write  = 1'b0;
    unique case (st_reg)
      RTC_ST_IDLE: begin
        if (ctrl_reg[0]) begin
          st_next   = (range == RTC_RANGE_AFTER) ? RTC_ST_ARMED : RTC_ST_POST;
          post_next = FULL_N;
          fill_next = '0;
          if (range == RTC_RANGE_BREAK || range == RTC_RANGE_BEFORE || range == RTC_RANGE_ABOUT) begin
            st_next = RTC_ST_ARMED;
          end
        end
      end
      RTC_ST_ARMED: begin
        // pre-trigger: circular recording except in after range, oldest overwritten
        do_write = store && (range != RTC_RANGE_AFTER);                            // [RL15]
        if (range == RTC_RANGE_BREAK && s_halt) begin
          st_next = RTC_ST_DONE;                                                   // [RL1]
        end else if (trig_fire && range == RTC_RANGE_BEFORE) begin
          st_next  = RTC_ST_DONE;                                                  // [RL2]
        end else if (trig_fire && range == RTC_RANGE_ABOUT) begin
          st_next   = RTC_ST_POST;                                                 // [RL3]
          post_next = HALF_N;
        end else if (trig_fire && range == RTC_RANGE_AFTER) begin
          st_next   = RTC_ST_POST;                                                 // [RL4]
          post_next = FULL_N;
          do_write  = store;
        end
      end
      RTC_ST_POST: begin
        // post-trigger countdown, full range also ends here
        do_write = store;                                                          // [RL5]
        if (store && post_reg == (DEPTH_LOG2+1)'(1)) begin
          st_next = RTC_ST_DONE;                                                   // [RL15]
        end
      end
      RTC_ST_DONE: st_next = RTC_ST_DONE;
    endcase
    if (do_write) begin
      wptr_next = wptr_reg + DEPTH_LOG2'(1);
      fill_next = (fill_reg == FULL_N) ? fill_reg : fill_reg + (DEPTH_LOG2+1)'(1);
      if (st_next == RTC_ST_POST || st_reg == RTC_ST_POST) begin
        post_next = post_next - (DEPTH_LOG2+1)'(1);
      end
    end
    if (!ctrl_reg[0] || clr_pulse) begin
      st_next = RTC_ST_IDLE;
    end
    if (clr_pulse) begin
      wptr_next = '0;
      fill_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= RTC_ST_IDLE;
      wptr_reg <= '0;
      fill_reg <= '0;
      post_reg <= '0;
      seq_reg  <= 2'd0;
      gate_reg <= 1'b0;
      ts_reg   <= '0;
    end else begin
      st_reg   <= st_next;
      wptr_reg <= wptr_next;
      fill_reg <= fill_next;
      post_reg <= post_next;
      seq_reg  <= seq_next;
      gate_reg <= gate_next;
      ts_reg   <= (ctrl_reg[0] && !clr_pulse) ? ts_reg + RTC_TS_W'(1) : (clr_pulse ? '0 : ts_reg);
    end
  end

  // trace entry write; no reset on storage to keep it plain memory
  always_ff @(posedge pclk) begin
    if (do_write) begin
      mem_reg[wptr_reg]    <= {s_addr, s_data, s_bhe_n, s_status, s_rnw, s_ext};  // [RL16]
      ts_mem_reg[wptr_reg] <= ts_reg;                                              // [RL16]
    end
  end

  // APB slave: zero wait, unmapped reads zero with pslverr
  logic [DEPTH_LOG2-1:0] rd_at;
  logic [EW-1:0]         rd_ent;
  logic                  acc;
  logic                  wacc;
  logic [7:0]            evt_off;
  assign acc    = psel && !penable;
  assign wacc   = psel && penable && pready_reg && pwrite; // writes land on the answering edge
  assign evt_off = paddr - RTC_OFF_EVT0;                   // event n sits at base plus 8n
  assign rd_at  = wptr_reg - DEPTH_LOG2'(fill_reg) + rdidx_reg;
  assign rd_ent = mem_reg[rd_at];
  always_comb begin
    ctrl_next    = {ctrl_reg[31:5], 1'b0, ctrl_reg[3:0]};
    wcond_next   = wcond_reg;
    comb_next    = comb_reg;
    evta_next    = evta_reg;
    evtk_next    = evtk_reg;
    rdidx_next   = rdidx_reg;
    prdata_next  = 32'h0000_0000;
    pready_next  = acc;
    pslverr_next = 1'b0;
    if (psel) begin
      if (paddr >= RTC_OFF_EVT0 && paddr < RTC_OFF_RDIDX) begin
        if (wacc && !paddr[2]) evta_next[evt_off[4:3]] = pwdata;
        if (wacc && paddr[2])  evtk_next[evt_off[4:3]] = pwdata;
        prdata_next = paddr[2] ? evtk_reg[evt_off[4:3]] : evta_reg[evt_off[4:3]];
      end else begin
        unique case (paddr)
          RTC_OFF_CTRL:   begin if (wacc) ctrl_next = pwdata; prdata_next = ctrl_reg; end
          RTC_OFF_STAT:   prdata_next = {28'h000_0000, trace_done, trace_active, st_reg};
          RTC_OFF_WCOND:  begin if (wacc) wcond_next = pwdata; prdata_next = wcond_reg; end
          RTC_OFF_COMB:   begin if (wacc) comb_next = pwdata; prdata_next = comb_reg; end
          RTC_OFF_RDIDX:  begin if (wacc) rdidx_next = pwdata[DEPTH_LOG2-1:0];
                                prdata_next = 32'(rdidx_reg); end
          RTC_OFF_RDADDR: prdata_next = {8'h00, rd_ent[EW-1 -: RTC_ADDR_W]};
          RTC_OFF_RDDATA: prdata_next = {rd_ent[RTC_DATA_W+13:0], 2'b00};
          RTC_OFF_RDTS:   prdata_next = ts_mem_reg[rd_at];
          RTC_OFF_COUNT:  prdata_next = 32'(fill_reg);
          default:        pslverr_next = acc;
        endcase
      end
    end
  end

  assign clr_pulse = ctrl_reg[4];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= RTC_CTRL_RST;
      wcond_reg   <= 32'h0000_0000;
      comb_reg    <= 32'h0000_0000;
      evta_reg    <= '{default: 32'h0000_0000};
      evtk_reg    <= '{default: {16'h0000, RTC_PASS_RST, 8'h00}};
      rdidx_reg   <= '0;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      trace_active <= 1'b0;
      trace_done   <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      wcond_reg   <= wcond_next;
      comb_reg    <= comb_next;
      evta_reg    <= evta_next;
      evtk_reg    <= evtk_next;
      rdidx_reg   <= rdidx_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      trace_active <= (st_next == RTC_ST_ARMED) || (st_next == RTC_ST_POST);
      trace_done   <= (st_next == RTC_ST_DONE);
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
endmodule : rtc_capture
`default_nettype wire

// ===== rtc_pkg.sv
// rtc_pkg: constants, register map and enumerations for the real-time trace capture block
// assumes: APB slave on pclk, 32-bit data, word-aligned registers
package rtc_pkg;
  // trace depth and range figures
  localparam int unsigned RTC_FULL_CYCLES = 262144;
  localparam int unsigned RTC_HALF_CYCLES = 131072;
  localparam int          RTC_ADDR_W      = 24;
  localparam int          RTC_DATA_W      = 16;
  localparam int          RTC_TS_W        = 32;
  localparam int          RTC_NEVT        = 4;
  // register byte offsets
  localparam logic [7:0] RTC_OFF_CTRL     = 8'h00;
  localparam logic [7:0] RTC_OFF_STAT     = 8'h04;
  localparam logic [7:0] RTC_OFF_WCOND    = 8'h08;
  localparam logic [7:0] RTC_OFF_COMB     = 8'h0C;
  localparam logic [7:0] RTC_OFF_EVT0     = 8'h10;
  localparam logic [7:0] RTC_OFF_RDIDX    = 8'h30;
  localparam logic [7:0] RTC_OFF_RDADDR   = 8'h34;
  localparam logic [7:0] RTC_OFF_RDDATA   = 8'h38;
  localparam logic [7:0] RTC_OFF_RDTS     = 8'h3C;
  localparam logic [7:0] RTC_OFF_COUNT    = 8'h40;
  // event register pair stride: address word then mask/pass/kind word
  localparam logic [7:0] RTC_EVT_STRIDE   = 8'h08;
  // reset values
  localparam logic [31:0] RTC_CTRL_RST    = 32'h0000_0000;
  localparam logic [7:0]  RTC_PASS_RST    = 8'h01;

  typedef enum logic [2:0] {
    RTC_RANGE_BREAK  = 3'b000,
    RTC_RANGE_BEFORE = 3'b001,
    RTC_RANGE_ABOUT  = 3'b010,
    RTC_RANGE_AFTER  = 3'b011,
    RTC_RANGE_FULL   = 3'b100
  } rtc_range_t;

  typedef enum logic [1:0] {
    RTC_WR_TOTAL   = 2'b00,
    RTC_WR_PICK    = 2'b01,
    RTC_WR_EXCLUDE = 2'b10
  } rtc_wmode_t;

  typedef enum logic [1:0] {
    RTC_GATE_CYCLE    = 2'b00,
    RTC_GATE_LEVEL    = 2'b01,
    RTC_GATE_INTERVAL = 2'b10
  } rtc_gate_t;

  typedef enum logic [1:0] {
    RTC_COMB_AND  = 2'b00,
    RTC_COMB_SAME = 2'b01,
    RTC_COMB_OR   = 2'b10,
    RTC_COMB_SEQ  = 2'b11
  } rtc_comb_t;

  typedef enum logic [2:0] {
    RTC_KIND_FETCH = 3'b000,
    RTC_KIND_DATA  = 3'b001,
    RTC_KIND_BIT   = 3'b010,
    RTC_KIND_INT   = 3'b011,
    RTC_KIND_TRIG  = 3'b100
  } rtc_kind_t;

  typedef enum logic [1:0] {
    RTC_ST_IDLE  = 2'b00,
    RTC_ST_ARMED = 2'b01,
    RTC_ST_POST  = 2'b10,
    RTC_ST_DONE  = 2'b11
  } rtc_state_t;
endpackage : rtc_pkg

// ===== rtc_event.sv
// rtc_event: one trace event detector with pass counter
// assumes: bus inputs already synchronous to pclk; clear pulse restarts the count
`timescale 1ns/100ps
`default_nettype none
module rtc_event
  import rtc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clr,
  input  wire logic                  cyc_valid,
  input  wire logic [RTC_ADDR_W-1:0] bus_addr,
  input  wire logic                  bus_rd,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_fetch,
  input  wire logic                  bus_bit,
  input  wire logic                  bus_int,
  input  wire logic                  ext_trig,
  input  wire logic [RTC_ADDR_W-1:0] match_addr,
  input  wire logic [RTC_ADDR_W-1:0] match_mask,
  input  wire rtc_kind_t             kind,
  input  wire logic [7:0]            pass_cnt,
  input  wire logic                  pass_one,
  output logic                       hit_now,
  output logic                       satisfied
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic       sat_reg;
  logic       sat_next;
  logic       raw;
  logic [7:0] need;

  // raw detector, one per event kind
  always_comb begin
    raw = 1'b0;
    unique case (kind)
      RTC_KIND_FETCH: raw = bus_fetch;                    // [RL12]
      RTC_KIND_DATA:  raw = bus_rd | bus_wr;              // [RL12]
      RTC_KIND_BIT:   raw = bus_bit;                      // [RL12]
      RTC_KIND_INT:   raw = bus_int;                      // [RL12]
      RTC_KIND_TRIG:  raw = ext_trig;                     // [RL12]
      default:        raw = 1'b0;
    endcase
    if (kind != RTC_KIND_TRIG && ((bus_addr ^ match_addr) & ~match_mask) != '0) begin
      raw = 1'b0;
    end
    raw = raw & cyc_valid;
  end

  // pass counter; zero programmed is treated as one
  always_comb begin
    need       = pass_one ? 8'h01 : ((pass_cnt == 8'h00) ? 8'h01 : pass_cnt); // [RL13]
    count_next = count_reg;
    sat_next   = sat_reg;
    if (clr) begin
      count_next = 8'h00;
      sat_next   = 1'b0;
    end else if (raw && !sat_reg) begin
      count_next = count_reg + 8'h01;
      if (count_reg + 8'h01 >= need) begin
        sat_next = 1'b1;                                  // [RL13]
      end
    end
    hit_now = raw && !sat_reg && (count_reg + 8'h01 >= need);
    if (pass_one) begin
      hit_now = raw;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
      sat_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      sat_reg   <= sat_next;
    end
  end

  assign satisfied = sat_reg;
endmodule : rtc_event
`default_nettype wire

// ===== rtc_mcu_model.sv
// mcu model: one traced bus cycle per pclk while en is high
// assumes: restart reloads the start address before a burst
`timescale 1ns/100ps
`default_nettype none
module rtc_mcu_model
  import rtc_pkg::*;
#(
  parameter logic [RTC_ADDR_W-1:0] BASE = 24'h001000
)(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  en,
  input  wire logic                  restart,
  output logic                       cyc_strobe_n,
  output logic [RTC_ADDR_W-1:0]      cyc_addr,
  output logic [RTC_DATA_W-1:0]      cyc_data,
  output logic                       cyc_bhe_n,
  output logic [3:0]                 cyc_status,
  output logic                       cyc_rnw,
  output logic                       cyc_fetch,
  output logic                       cyc_bit,
  output logic                       cyc_int,
  output logic [7:0]                 ext_in
);
  logic [RTC_ADDR_W-1:0] addr_reg;
  // idle bus shows the inverse of the last value so stale data never matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg     <= BASE;
      cyc_strobe_n <= 1'b1;
      cyc_addr     <= '0;
      cyc_data     <= '0;
    end else begin
      addr_reg     <= restart ? BASE : addr_reg + RTC_ADDR_W'(en);
      cyc_strobe_n <= ~en;
      cyc_addr     <= en ? addr_reg : ~cyc_addr;
      cyc_data     <= en ? addr_reg[15:0] : ~cyc_data;
    end
  end
  // every cycle is a word fetch; the trigger pins stay low
  assign cyc_bhe_n  = cyc_addr[0];
  assign cyc_status = cyc_strobe_n ? 4'h0 : 4'h3;
  assign cyc_rnw    = 1'b1;
  assign cyc_fetch  = ~cyc_strobe_n;
  assign cyc_bit    = 1'b0;
  assign cyc_int    = 1'b0;
  assign ext_in     = 8'h00;
endmodule // rtc_mcu_model
`default_nettype wire

// ===== rtc_chk.sv
// checker: apb answer timing and trace status relations
// assumes: bound to rtc_capture, one clock domain
`timescale 1ns/100ps
`default_nettype none
module rtc_chk
  import rtc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        user_halt,
  input  wire logic        trace_active,
  input  wire logic        trace_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       ctl_wr;
  logic [2:0] range_reg;
  logic [2:0] range_next;
  // range mirror, so halt checks only apply in stop-referenced mode
  assign ctl_wr = psel && penable && pready && pwrite && paddr == RTC_OFF_CTRL;
  always_comb begin
    range_next = ctl_wr ? pwdata[3:1] : range_reg;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_reg <= 3'h0;
    end else begin
      range_reg <= range_next;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_halt;
    trace_active && user_halt && range_reg == RTC_RANGE_BREAK;
  endsequence
  chk_ready_next: assert property (s_setup |=> pready) else $error("no ready after setup");
  chk_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held two cycles");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error with data");
  chk_done_idle: assert property (trace_done |-> !trace_active) else $error("done while active");
  chk_done_hold: assert property ($fell(trace_done) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("done dropped alone");
  chk_halt_stop: assert property (s_halt |-> ##[1:5] trace_done) else $error("halt did not freeze");
endmodule // rtc_chk
bind rtc_capture rtc_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .user_halt, .trace_active, .trace_done);
`default_nettype wire

// ===== rtc_capture_test.sv
// testbench: apb scenarios over trace ranges and write filters
// assumes: rtc_mcu_model plays the traced cpu bus
`timescale 1ns/100ps
`default_nettype none
module rtc_capture_test;
  import rtc_pkg::*;
  localparam logic [23:0] BASE = 24'h001000;
  localparam logic [31:0] NFULL = 32'h10; // sim depth of 16 entries
  localparam logic [7:0]  WC [3] = '{8'h01, 8'h02, 8'h05};
  localparam logic [31:0] WN [3] = '{32'h1, 32'h10, 32'h1};
  localparam rtc_range_t  RG [3] = '{RTC_RANGE_BEFORE, RTC_RANGE_ABOUT, RTC_RANGE_AFTER};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        en = 1'b0, restart = 1'b0, user_halt = 1'b0;
  logic        pready, pslverr, trace_active, trace_done;
  logic        cyc_strobe_n, cyc_bhe_n, cyc_rnw, cyc_fetch, cyc_bit, cyc_int;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  ext_in;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [3:0]  cyc_status;
  logic [23:0] cyc_addr;
  logic [15:0] cyc_data;
  int          miscompares = 0, n_tests = 0;
  rtc_capture #(.DEPTH_LOG2(4)) DUT (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .cyc_strobe_n, .cyc_addr, .cyc_data, .cyc_bhe_n, .cyc_status,
    .cyc_rnw, .cyc_fetch, .cyc_bit, .cyc_int, .ext_in, .user_halt, .trace_active, .trace_done);
  rtc_mcu_model #(.BASE(BASE)) u_mcu (.pclk, .presetn, .en, .restart, .cyc_strobe_n, .cyc_addr, .cyc_data,
    .cyc_bhe_n, .cyc_status, .cyc_rnw, .cyc_fetch, .cyc_bit, .cyc_int, .ext_in);
  always #20 pclk = ~pclk;
  task automatic test_done;
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(s, x, q);
  endtask
  // clear, program filter and combination, then start
  task automatic cfg(input rtc_range_t r, input logic [7:0] w, input logic [7:0] c);
    wr(RTC_OFF_CTRL, {27'h0, 1'b1, r, 1'b0});
    wr(RTC_OFF_WCOND, {24'h0, w});
    wr(RTC_OFF_COMB, {24'h0, c});
    wr(RTC_OFF_CTRL, {28'h0, r, 1'b1});
  endtask
  // burst of n cycles, then room for the two-flop input delay
  task automatic feed(input int n);
    @(posedge pclk);
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    en <= 1'b1;
    repeat (n) @(posedge pclk);
    en <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done();
  end
  initial begin
    logic [31:0] q;
    logic        e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl reset", RTC_OFF_CTRL, RTC_CTRL_RST);
    apb(1'b0, 8'h80, 32'h0, q, e);
    cmp("unmapped error", 32'h1, {31'h0, e});
    cmp("unmapped data", 32'h0, q);
    wr(RTC_OFF_EVT0, {8'h0, BASE + 24'h14});
    wr(RTC_OFF_EVT0 + 8'h4, {16'h0, RTC_PASS_RST, 5'h0, RTC_KIND_FETCH});
    cfg(RTC_RANGE_FULL, 8'h00, 8'h00);
    feed(20);
    rdc("full count", RTC_OFF_COUNT, NFULL);
    wr(RTC_OFF_RDIDX, 32'h0);
    rdc("full oldest", RTC_OFF_RDADDR, {8'h0, BASE});
    rdc("full status", RTC_OFF_STAT, {28'h0, 2'b10, RTC_ST_DONE});
    foreach (WC[i]) begin
      cfg(RTC_RANGE_FULL, WC[i], 8'h12);
      feed(24);
      rdc("filter count", RTC_OFF_COUNT, WN[i]);
    end
    foreach (RG[i]) begin
      cfg(RG[i], 8'h00, 8'h12);
      feed(40);
      cmp("range done", 32'h1, {31'h0, trace_done});
      rdc("range count", RTC_OFF_COUNT, NFULL);
    end
    wr(RTC_OFF_RDIDX, 32'h0);
    rdc("after oldest", RTC_OFF_RDADDR, {8'h0, BASE + 24'h14});
    cfg(RTC_RANGE_BREAK, 8'h00, 8'h00);
    feed(30);
    cmp("break running", 32'h1, {31'h0, trace_active});
    user_halt <= 1'b1;
    repeat (6) @(posedge pclk);
    cmp("break done", 32'h1, {31'h0, trace_done});
    rdc("break count", RTC_OFF_COUNT, NFULL);
    wr(RTC_OFF_RDIDX, 32'hF);
    rdc("break newest", RTC_OFF_RDADDR, {8'h0, BASE + 24'h1D});
    user_halt <= 1'b0;
    test_done();
  end
endmodule // rtc_capture_test
`default_nettype wire
